// ### design/dtcs_deadtime_carrier_stage.v
// Function
// - Both pair outputs derivable from A input.
// - Edge delays load only through shadow update.
// - Nine switches, each its own control.
// - Every switch combination is supported.
// - Typical modes: A feeds both paths.
// - Both bypasses set: pass inputs undelayed.
// - Invert pair selects output polarity mode.
// - A bypass only: B is fall-delayed A.
// - B bypass only: A is rise-delayed A.
// - Independent 16-bit delays in dead-time periods.
// - Dead-time clock: PWM or timer clock.
// - Carrier chops active time into pulses.
// - Carrier rate, duty from divider, duty fields.
// - First pulse: 8*(div+1)*(width+1) clocks.
// - After first pulse, chop at carrier rate.
// - Sustain duty is duty field over eight.
// - One enable bit switches carrier on.

`include "dtcs_map.vh"

`default_nettype none

// Delays one chosen edge of a signal; the other edge passes at once.
module dtcs_edge_delay #(
  parameter DELAY_W = `DTCS_DELAY_W,
  parameter DELAYED_LEVEL = 1
) (
  // Clock and reset.
  input wire core_clk,
  input wire rstn,
  // Dead-time clock enable.
  input wire dt_tick,
  // Delay in dead-time clock periods.
  input wire [DELAY_W-1:0] delay,
  // Signal path.
  input wire sig_in,
  output wire sig_out
);

  localparam [0:0] LVL = (DELAYED_LEVEL != 0) ? 1'b1 : 1'b0;

  reg [DELAY_W-1:0] cnt_r;
  reg [DELAY_W-1:0] cnt_nxt;
  reg out_r;
  reg out_nxt;

  assign sig_out = out_r;

  // The counter is reloaded while the input sits at the undelayed level, so a
  // short pulse toward the delayed level is dropped when the input returns.
  always @* begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (sig_in != LVL) begin
      out_nxt = sig_in;
      cnt_nxt = delay;
    end else if (out_r != sig_in) begin
      if (cnt_r == {DELAY_W{1'b0}}) begin
        out_nxt = sig_in;
      end else if (dt_tick) begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  // Both paths leave reset low, so no output pulse follows reset.
  always @(posedge core_clk) begin
    if (!rstn) begin
      cnt_r <= {DELAY_W{1'b0}};
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

endmodule // dtcs_edge_delay

// Chops the active time of one signal with a one-shot pulse and a carrier.
module dtcs_carrier_chan #(
  parameter DIV_W = `DTCS_DIV_W,
  parameter SHOT_W = `DTCS_SHOT_W,
  parameter DUTY_W = `DTCS_DUTY_W
) (
  // Clock and reset.
  input wire core_clk,
  input wire rstn,
  // Carrier settings.
  input wire carrier_on,
  input wire [DIV_W-1:0] carrier_divider,
  input wire [DUTY_W-1:0] carrier_sustain_duty,
  input wire [SHOT_W-1:0] first_pulse_width,
  // Signal path.
  input wire sig_in,
  output wire sig_out
);

  reg [DIV_W-1:0] pre_r;
  reg [DIV_W-1:0] pre_nxt;
  reg [2:0] phase_r;
  reg [2:0] phase_nxt;
  reg [SHOT_W-1:0] shot_r;
  reg [SHOT_W-1:0] shot_nxt;
  reg shot_on_r;
  reg shot_on_nxt;
  reg out_r;
  wire chop;

  assign chop = shot_on_r | (phase_r < carrier_sustain_duty);
  assign sig_out = out_r;

  always @* begin
    pre_nxt = pre_r + 1'b1;
    phase_nxt = phase_r;
    shot_nxt = shot_r;
    shot_on_nxt = shot_on_r;
    if (!sig_in) begin
      // Counters stay armed while inactive so the next interval starts clean.
      pre_nxt = {DIV_W{1'b0}};
      phase_nxt = 3'h0;
      shot_nxt = {SHOT_W{1'b0}};
      shot_on_nxt = 1'b1;
    end else if (pre_r == carrier_divider) begin
      pre_nxt = {DIV_W{1'b0}};
      phase_nxt = phase_r + 1'b1;
      if (phase_r == `DTCS_PHASE_LAST && shot_on_r) begin
        if (shot_r == first_pulse_width) begin
          shot_on_nxt = 1'b0;
        end else begin
          shot_nxt = shot_r + 1'b1;
        end
      end
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      pre_r <= {DIV_W{1'b0}};
      phase_r <= 3'h0;
      shot_r <= {SHOT_W{1'b0}};
      shot_on_r <= 1'b1;
    end else begin
      pre_r <= pre_nxt;
      phase_r <= phase_nxt;
      shot_r <= shot_nxt;
      shot_on_r <= shot_on_nxt;
    end
  end

  // The output is registered so the gate driver never sees a decode glitch.
  always @(posedge core_clk) begin
    if (!rstn) begin
      out_r <= 1'b0;
    end else if (carrier_on) begin
      out_r <= sig_in & chop;
    end else begin
      out_r <= sig_in;
    end
  end

endmodule // dtcs_carrier_chan

module dtcs_deadtime_carrier_stage #(
  parameter DELAY_W = `DTCS_DELAY_W,
  parameter DIV_W = `DTCS_DIV_W,
  parameter SHOT_W = `DTCS_SHOT_W,
  parameter DUTY_W = `DTCS_DUTY_W
) (
  // Clock and reset.
  input wire core_clk,
  input wire rstn,
  // One-cycle enable at the timer clock rate.
  input wire timer_tick,
  // Generator outputs.
  input wire gen_a_in,
  input wire gen_b_in,
  // Dead-time switches.
  input wire second_output_bypass,
  input wire first_output_bypass,
  input wire rise_path_invert,
  input wire fall_path_invert,
  input wire rise_path_source_sel,
  input wire fall_path_source_sel,
  input wire first_output_swap,
  input wire second_output_swap,
  input wire dual_edge_mode,
  input wire deadtime_clock_select,
  // Delay shadow values and their update strobe.
  input wire [DELAY_W-1:0] rise_delay_config,
  input wire [DELAY_W-1:0] fall_delay_config,
  input wire delay_shadow_load,
  // Carrier settings.
  input wire carrier_on,
  input wire [DIV_W-1:0] carrier_divider,
  input wire [DUTY_W-1:0] carrier_sustain_duty,
  input wire [SHOT_W-1:0] first_pulse_width,
  // Outputs to the gate drivers.
  output wire pwm_chan_first_out,
  output wire pwm_chan_second_out,
  // Active delay values.
  output reg [DELAY_W-1:0] rise_delay_count,
  output reg [DELAY_W-1:0] fall_delay_count
);

  wire dt_tick;
  reg rise_src;
  reg fall_src;
  wire rise_dly;
  wire fall_dly;
  wire rise_path;
  wire fall_path;
  reg first_pre;
  reg second_pre;
  reg first_dt;
  reg second_dt;

  // Returns the second value when the select is set, else the first.
  function dtcs_pick;
    input sel;
    input first_val;
    input second_val;
    begin
      if (sel) begin
        dtcs_pick = second_val;
      end else begin
        dtcs_pick = first_val;
      end
    end
  endfunction

  // Applies the polarity switch of one delay path.
  function dtcs_polar;
    input level;
    input invert;
    begin
      dtcs_polar = level ^ invert;
    end
  endfunction

  // Software writes reach the active delays only on the update strobe.
  always @(posedge core_clk) begin
    if (!rstn) begin
      rise_delay_count <= `DTCS_DELAY_RST;
      fall_delay_count <= `DTCS_DELAY_RST;
    end else if (delay_shadow_load) begin
      rise_delay_count <= rise_delay_config;
      fall_delay_count <= fall_delay_config;
    end
  end

  // The PWM clock is this clock itself, so it ticks every cycle.
  assign dt_tick = (deadtime_clock_select == `DTCS_DTCLK_TIMER) ? timer_tick : 1'b1;

  // With both selects low the A input feeds both delay paths.
  always @* begin
    rise_src = dtcs_pick(rise_path_source_sel, gen_a_in, gen_b_in);
    fall_src = dtcs_pick(fall_path_source_sel, gen_a_in, gen_b_in);
    // Dual-edge mode cascades the rise path into the fall path.
    if (dual_edge_mode) begin
      fall_src = rise_dly;
    end
  end

  dtcs_edge_delay #(
    .DELAY_W(DELAY_W),
    .DELAYED_LEVEL(1)
  ) u_rise (
    .core_clk(core_clk),
    .rstn(rstn),
    .dt_tick(dt_tick),
    .delay(rise_delay_count),
    .sig_in(rise_src),
    .sig_out(rise_dly)
  );

  dtcs_edge_delay #(
    .DELAY_W(DELAY_W),
    .DELAYED_LEVEL(0)
  ) u_fall (
    .core_clk(core_clk),
    .rstn(rstn),
    .dt_tick(dt_tick),
    .delay(fall_delay_count),
    .sig_in(fall_src),
    .sig_out(fall_dly)
  );

  assign rise_path = dtcs_polar(rise_dly, rise_path_invert);
  assign fall_path = dtcs_polar(fall_dly, fall_path_invert);

  // Each switch acts on its own, so every combination is legal.
  always @* begin
    first_pre = dtcs_pick(first_output_bypass, rise_path, gen_a_in);
    second_pre = dtcs_pick(second_output_bypass, fall_path, gen_b_in);
    // Swaps act after bypass and polarity, each output on its own.
    first_dt = first_pre;
    second_dt = second_pre;
    if (first_output_swap) begin
      first_dt = second_pre;
    end
    if (second_output_swap) begin
      second_dt = first_pre;
    end
  end

  dtcs_carrier_chan #(
    .DIV_W(DIV_W),
    .SHOT_W(SHOT_W),
    .DUTY_W(DUTY_W)
  ) u_car_first (
    .core_clk(core_clk),
    .rstn(rstn),
    .carrier_on(carrier_on),
    .carrier_divider(carrier_divider),
    .carrier_sustain_duty(carrier_sustain_duty),
    .first_pulse_width(first_pulse_width),
    .sig_in(first_dt),
    .sig_out(pwm_chan_first_out)
  );

  dtcs_carrier_chan #(
    .DIV_W(DIV_W),
    .SHOT_W(SHOT_W),
    .DUTY_W(DUTY_W)
  ) u_car_second (
    .core_clk(core_clk),
    .rstn(rstn),
    .carrier_on(carrier_on),
    .carrier_divider(carrier_divider),
    .carrier_sustain_duty(carrier_sustain_duty),
    .first_pulse_width(first_pulse_width),
    .sig_in(second_dt),
    .sig_out(pwm_chan_second_out)
  );

endmodule // dtcs_deadtime_carrier_stage

`default_nettype wire

// ### pkg/dtcs_map.vh
`ifndef DTCS_MAP_VH
`define DTCS_MAP_VH

// Widths of the delay, carrier divider, one-shot width and duty fields.
`define DTCS_DELAY_W 16
`define DTCS_DIV_W 4
`define DTCS_SHOT_W 4
`define DTCS_DUTY_W 3

// Reset value of the active edge delays.
`define DTCS_DELAY_RST 16'h0000

// The carrier period in carrier clock ticks, and the last phase of it.
`define DTCS_CARRIER_PHASES 8
`define DTCS_PHASE_LAST 3'h7

// Dead-time clock select codes.
`define DTCS_DTCLK_PWM 1'b0
`define DTCS_DTCLK_TIMER 1'b1

`endif

// ### dv/dtcs_gate_drv.sv
`default_nettype none
module dtcs_gate_drv (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic pwm_chan_first_out,
  input wire logic pwm_chan_second_out,
  output logic [15:0] overlap
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counts cycles in which both switches of the half bridge would conduct.
  always @(posedge core_clk) begin
    if (clr) overlap <= 16'h0;
    else if (pwm_chan_first_out && pwm_chan_second_out) overlap <= overlap + 16'h1;
  end
endmodule // dtcs_gate_drv
`default_nettype wire

// ### dv/dtcs_stage_checker.sv
`default_nettype none
module dtcs_stage_checker (
  input wire core_clk, rstn, gen_a_in, gen_b_in, first_output_bypass, second_output_bypass,
  input wire first_output_swap, second_output_swap, rise_path_invert, rise_path_source_sel,
  input wire carrier_on, delay_shadow_load, pwm_chan_first_out, pwm_chan_second_out,
  input wire [3:0] carrier_divider, first_pulse_width,
  input wire [2:0] carrier_sustain_duty,
  input wire [15:0] rise_delay_config, fall_delay_config, rise_delay_count, fall_delay_count
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] run_r;
  wire ck = carrier_on && first_output_bypass && !first_output_swap;
  wire [11:0] cfg = {ck, carrier_divider, carrier_sustain_duty, first_pulse_width};
  wire [15:0] dv = {12'h0, carrier_divider} + 16'h1;
  wire [15:0] sh = dv * ({12'h0, first_pulse_width} + 16'h1) * 16'h8;
  wire [15:0] ph = (run_r - sh - 16'h1) % (dv * 16'h8);
  wire chop = run_r <= sh || ph < {13'h0, carrier_sustain_duty} * dv;
  wire dlm = !first_output_bypass && !first_output_swap && !rise_path_invert &&
    !rise_path_source_sel && !carrier_on;
  // A run is counted only from a rising input under a settled carrier setup.
  always @(posedge core_clk) begin
    if (!rstn || !ck || !gen_a_in || !$stable(cfg)) run_r <= 16'h0;
    else if (run_r != 16'h0 || !$past(gen_a_in)) run_r <= run_r + 16'h1;
  end
  a_shadow_load: assert property (
    delay_shadow_load |=> rise_delay_count == $past(rise_delay_config) &&
    fall_delay_count == $past(fall_delay_config)) else $error("delay load missed");
  a_shadow_hold: assert property (
    !delay_shadow_load |=> $stable(rise_delay_count) && $stable(fall_delay_count))
    else $error("delay moved unloaded");
  a_first_bypass: assert property (
    first_output_bypass && !first_output_swap && !carrier_on |=>
    pwm_chan_first_out == $past(gen_a_in)) else $error("first bypass wrong");
  a_second_bypass: assert property (
    second_output_bypass && !second_output_swap && !carrier_on |=>
    pwm_chan_second_out == $past(gen_b_in)) else $error("second bypass wrong");
  a_swap_first: assert property (
    first_output_swap && second_output_bypass && !carrier_on |=>
    pwm_chan_first_out == $past(gen_b_in)) else $error("swap wrong");
  a_swap_second: assert property (
    second_output_swap && first_output_bypass && !carrier_on |=>
    pwm_chan_second_out == $past(gen_a_in)) else $error("second swap wrong");
  a_idle_low: assert property (
    first_output_bypass && !first_output_swap && !gen_a_in |=> !pwm_chan_first_out)
    else $error("idle not low");
  a_carrier_chop: assert property (
    run_r != 16'h0 && $stable(cfg) |-> pwm_chan_first_out == chop) else $error("chop wrong");
  a_fall_prompt: assert property (
    dlm && $fell(gen_a_in) ##1 dlm |=> !pwm_chan_first_out) else $error("fall late");
endmodule // dtcs_stage_checker
bind dtcs_deadtime_carrier_stage dtcs_stage_checker u_chk (.*);
`default_nettype wire

// ### dv/dtcs_deadtime_carrier_stage_tb.sv
`default_nettype none
module dtcs_deadtime_carrier_stage_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rstn = 0, timer_tick = 0, gen_a_in = 0, gen_b_in = 0, clr = 0;
  logic deadtime_clock_select = 0, delay_shadow_load = 0, carrier_on = 0;
  logic [8:0] sw = 9'h0;
  logic [15:0] rise_delay_config = 16'h0, fall_delay_config = 16'h0, n, d, f;
  logic [3:0] carrier_divider = 4'h0, first_pulse_width = 4'h0;
  logic [2:0] carrier_sustain_duty = 3'h0;
  wire pwm_chan_first_out, pwm_chan_second_out;
  wire [15:0] rise_delay_count, fall_delay_count, overlap;
  wire second_output_bypass = sw[0], first_output_bypass = sw[1], rise_path_invert = sw[2];
  wire fall_path_invert = sw[3], rise_path_source_sel = sw[4], fall_path_source_sel = sw[5];
  wire first_output_swap = sw[6], second_output_swap = sw[7], dual_edge_mode = sw[8];
  int fail_count = 0, comparisons = 0;
  dtcs_deadtime_carrier_stage u_dut (.*);
  dtcs_gate_drv u_drv (.*);
  always #4 core_clk = ~core_clk;
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic load(input logic [15:0] r, input logic [15:0] q);
    rise_delay_config = r;
    fall_delay_config = q;
    delay_shadow_load = 1;
    tick(1);
    delay_shadow_load = 0;
    tick(1);
  endtask
  // Drives the first input and returns the cycle of the first change of one output.
  task automatic flip(input bit sel, input logic a);
    logic v;
    v = sel ? pwm_chan_second_out : pwm_chan_first_out;
    gen_a_in = a;
    n = 16'h0;
    for (int i = 1; i < 60; i++) begin
      tick(1);
      if (n == 16'h0 && (sel ? pwm_chan_second_out : pwm_chan_first_out) !== v) n = 16'(i);
    end
  endtask
  function automatic logic [15:0] burst(input logic [3:0] v, input logic [3:0] w,
    input logic [2:0] u);
    return 16'((8 * (w + 1) + u) * (v + 1));
  endfunction
  initial begin
    void'($urandom(25029));
    tick(3);
    rstn = 1;
    rise_delay_config = 16'($urandom);
    tick(2);
    cmp("rise_cnt", 16'h0, rise_delay_count);
    for (int m = 0; m < 4; m++) begin
      sw = {5'h0, 2'(m), 2'h0};
      d = 16'($urandom_range(0, 40));
      f = 16'($urandom_range(0, 40));
      load(d, f);
      clr = 1;
      tick(1);
      clr = 0;
      flip(0, 1);
      cmp("rise_dly", d + 16'h2, n);
      flip(1, 0);
      cmp("fall_dly", f + 16'h2, n);
      cmp("levels", 16'(m), {14'h0, pwm_chan_second_out, pwm_chan_first_out});
      if (m == 2) cmp("overlap", 16'h0, overlap);
    end
    sw = 9'h0;
    load(16'ha, 16'ha);
    gen_a_in = 1;
    tick(4);
    flip(0, 0);
    cmp("short", 16'h0, n);
    deadtime_clock_select = 1;
    load(16'h3, 16'h3);
    flip(0, 1);
    cmp("no_tick", 16'h0, n);
    flip(0, 0);
    timer_tick = 1;
    flip(0, 1);
    cmp("ticked", 16'h5, n);
    deadtime_clock_select = 0;
    sw = 9'h2;
    carrier_on = 1;
    repeat (10) begin
      carrier_divider = 4'($urandom_range(0, 2));
      first_pulse_width = 4'($urandom_range(0, 3));
      carrier_sustain_duty = 3'($urandom);
      gen_a_in = 0;
      tick(2);
      gen_a_in = 1;
      tick(1);
      n = 16'h0;
      while (pwm_chan_first_out === 1'b1 && n < 16'd600) begin
        tick(1);
        n++;
      end
      cmp("burst", burst(carrier_divider, first_pulse_width, carrier_sustain_duty), n);
      tick($urandom_range(0, 30));
    end
    for (int i = 0; i < 4000; i++) begin
      if (i % 16 == 0) {sw, carrier_on, deadtime_clock_select} = 11'($urandom);
      {gen_a_in, gen_b_in, timer_tick, delay_shadow_load} = 4'($urandom);
      rise_delay_config = 16'($urandom_range(0, 5));
      fall_delay_config = 16'($urandom_range(0, 5));
      rstn = (i != 2000);
      tick(1);
    end
    finish_test;
  end
endmodule // dtcs_deadtime_carrier_stage_tb
`default_nettype wire
